// ==== fpcs_pkg.sv ====
// Constants for the floating-point control and status register bank.
// Assumes the core decodes system-register moves into op0..op2 fields.
package fpcs_pkg;
    // Move encoding shared by control and status
    localparam logic [1:0] FPCS_OP0 = 2'h3;
    localparam logic [2:0] FPCS_OP1 = 3'h3;
    localparam logic [3:0] FPCS_CRN = 4'h4;
    localparam logic [3:0] FPCS_CRM = 4'h4;
    localparam logic [2:0] FPCS_OP2_CTRL = 3'h0;
    localparam logic [2:0] FPCS_OP2_STAT = 3'h1;
    // Feature registers
    localparam logic [1:0] FPCS_FEAT_OP0 = 2'h3;
    localparam logic [2:0] FPCS_FEAT_OP1 = 3'h0;
    localparam logic [3:0] FPCS_FEAT_CRN = 4'h0;
    localparam logic [3:0] FPCS_FEAT_CRM = 4'h3;
    localparam logic [2:0] FPCS_OP2_FEAT0 = 3'h0;
    localparam logic [2:0] FPCS_OP2_FEAT1 = 3'h1;
    localparam logic [2:0] FPCS_OP2_FEAT2 = 3'h2;
    localparam logic [31:0] FPCS_FEAT0_VAL = 32'h1011_0222;
    localparam logic [31:0] FPCS_FEAT1_VAL = 32'h1321_1111;
    localparam logic [31:0] FPCS_FEAT2_VAL = 32'h0000_0043;
    // Control layout
    localparam logic [31:0] FPCS_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] FPCS_CTRL_MASK = 32'h07c8_0000;
    localparam int FPCS_AHP_BIT = 26;
    localparam int FPCS_DN_BIT = 25;
    localparam int FPCS_FZ_BIT = 24;
    localparam int FPCS_RM_HI = 23;
    localparam int FPCS_RM_LO = 22;
    localparam int FPCS_HALF_FLUSH_ZERO_ENABLE_BIT = 19;
    // Status layout
    localparam logic [31:0] FPCS_STAT_MASK = 32'hf800_009f;
    localparam int FPCS_NZCV_HI = 31;
    localparam int FPCS_NZCV_LO = 28;
    localparam int FPCS_QC_BIT = 27;
    localparam int FPCS_EXC_W = 6;
    // Sticky exception positions: ioc dzc ofc ufc ixc idc
    localparam logic [31:0] FPCS_EXC_POS = {8'h07, 8'h04, 8'h03, 8'h02};
    localparam logic [15:0] FPCS_EXC_POS_LO = {8'h01, 8'h00};
    typedef enum logic [1:0] {
        FPCS_RN, FPCS_RP, FPCS_RM, FPCS_RZ
    } fpcs_round_t;
endpackage

// ==== fpcs_sticky.sv ====
// One sticky bit: set by hardware, cleared by a written zero.
// Assumes set and write strobes come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module fpcs_sticky
(
    input wire logic mclk,
    input wire logic set,
    input wire logic wr,
    input wire logic wr_bit,
    output logic q
);
    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge mclk)
    begin
        if (set)
            q <= 1'b1;
        else if (wr)
            q <= wr_bit;
    end
endmodule
`default_nettype wire

// ==== fpcs_regs.sv ====
// Floating-point control, status and feature register bank.
// Assumes the pipeline presents one decoded system-register move per
// cycle and that the datapath reports events as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module fpcs_regs
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [1:0] acc_op0,
    input wire logic [2:0] acc_op1,
    input wire logic [3:0] acc_crn,
    input wire logic [3:0] acc_crm,
    input wire logic [2:0] acc_op2,
    input wire logic [31:0] acc_wdata,
    input wire logic legacy_valid,
    input wire logic legacy_write,
    input wire logic [31:0] legacy_wdata,
    input wire logic cmp_valid,
    input wire logic cmp_legacy,
    input wire logic [3:0] cmp_nzcv,
    input wire logic sat_event,
    input wire logic [fpcs_pkg::FPCS_EXC_W-1:0] exc_event,
    output logic rd_valid,
    output logic rd_hit,
    output logic [31:0] rd_data,
    output logic [31:0] legacy_rdata,
    output logic [3:0] state_nzcv,
    output logic state_nzcv_valid,
    output logic alt_half_format,
    output logic default_nan_enable,
    output logic flush_zero_enable,
    output fpcs_pkg::fpcs_round_t rounding_select,
    output logic half_flush_zero_enable
);
    import fpcs_pkg::*;

    logic [31:0] fp_control;
    logic [31:0] fp_status;
    logic [31:0] fp_status_rd;
    logic [3:0] nzcv;
    logic saturation_sticky;
    logic [FPCS_EXC_W-1:0] exc_q;
    logic base_hit;
    logic feat_hit;
    logic sel_ctrl;
    logic sel_stat;
    logic ctrl_wr;
    logic stat_wr;
    logic [31:0] stat_wval;
    logic [31:0] next_rd_data;
    logic next_rd_hit;

    // Decode of the move encoding
    assign base_hit = acc_op0 == FPCS_OP0 && acc_op1 == FPCS_OP1
        && acc_crn == FPCS_CRN && acc_crm == FPCS_CRM;
    assign feat_hit = acc_op0 == FPCS_FEAT_OP0 && acc_op1 == FPCS_FEAT_OP1
        && acc_crn == FPCS_FEAT_CRN && acc_crm == FPCS_FEAT_CRM;
    assign sel_ctrl = base_hit && acc_op2 == FPCS_OP2_CTRL;
    assign sel_stat = base_hit && acc_op2 == FPCS_OP2_STAT;

    // Either view writes the same state; the legacy word carries both
    assign ctrl_wr = (acc_valid && acc_write && sel_ctrl)
        || (legacy_valid && legacy_write);
    assign stat_wr = (acc_valid && acc_write && sel_stat)
        || (legacy_valid && legacy_write);
    // Direct move has priority should both views write at once
    assign stat_wval = (acc_valid && acc_write && sel_stat)
        ? acc_wdata : legacy_wdata;

    // Control register; reserved bits are masked away on write
    always_ff @(posedge mclk)
    begin
        if (rst)
            fp_control <= FPCS_CTRL_RESET;
        else if (acc_valid && acc_write && sel_ctrl)
            fp_control <= acc_wdata & FPCS_CTRL_MASK;
        else if (ctrl_wr)
            fp_control <= legacy_wdata & FPCS_CTRL_MASK;
    end

    // Comparison flags: no reset, only legacy-state compares land here
    always_ff @(posedge mclk)
    begin
        if (cmp_valid && cmp_legacy)
            nzcv <= cmp_nzcv;
        else if (stat_wr)
            nzcv <= stat_wval[FPCS_NZCV_HI:FPCS_NZCV_LO];
    end

    // Wide-state compares go out to the processor flags instead
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_nzcv <= 4'h0;
            state_nzcv_valid <= 1'b0;
        end
        else
        begin
            state_nzcv_valid <= cmp_valid && !cmp_legacy;
            if (cmp_valid && !cmp_legacy)
                state_nzcv <= cmp_nzcv;
        end
    end

    // Saturation flag, reset value left undefined on purpose
    fpcs_sticky u_sat
    (
        .mclk(mclk),
        .set(sat_event),
        .wr(stat_wr),
        .wr_bit(stat_wval[FPCS_QC_BIT]),
        .q(saturation_sticky)
    );

    // Cumulative exception flags, one per event line
    genvar gi;
    generate
        for (gi = 0; gi < FPCS_EXC_W; gi++)
        begin : g_exc
            // Wrapped index keeps both arms in range at elaboration
            localparam logic [7:0] POS = (gi < 2)
                ? FPCS_EXC_POS_LO[8*(gi%2) +: 8]
                : FPCS_EXC_POS[8*((gi+2)%4) +: 8];
            fpcs_sticky u_exc
            (
                .mclk(mclk),
                .set(exc_event[gi]),
                .wr(stat_wr),
                .wr_bit(stat_wval[POS[4:0]]),
                .q(exc_q[gi])
            );
        end
    endgenerate

    // Assemble status; reserved positions stay zero
    always_comb
    begin
        fp_status_rd = 32'h0000_0000;
        fp_status_rd[FPCS_NZCV_HI:FPCS_NZCV_LO] = nzcv;
        fp_status_rd[FPCS_QC_BIT] = saturation_sticky;
        for (int i = 0; i < FPCS_EXC_W; i++)
        begin
            if (i < 2)
                fp_status_rd[FPCS_EXC_POS_LO[8*(i%2) +: 5]] = exc_q[i];
            else
                fp_status_rd[FPCS_EXC_POS[8*((i+2)%4) +: 5]] = exc_q[i];
        end
        fp_status = fp_status_rd & FPCS_STAT_MASK;
    end

    // Read mux; feature words are constants so writes fall away
    always_comb
    begin
        next_rd_data = 32'h0000_0000;
        next_rd_hit = 1'b1;
        if (sel_ctrl)
            next_rd_data = fp_control;
        else if (sel_stat)
            next_rd_data = fp_status;
        else if (feat_hit && acc_op2 == FPCS_OP2_FEAT0)
            next_rd_data = FPCS_FEAT0_VAL;
        else if (feat_hit && acc_op2 == FPCS_OP2_FEAT1)
            next_rd_data = FPCS_FEAT1_VAL;
        else if (feat_hit && acc_op2 == FPCS_OP2_FEAT2)
            next_rd_data = FPCS_FEAT2_VAL;
        else
            next_rd_hit = 1'b0;
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rd_valid <= 1'b0;
            rd_hit <= 1'b0;
            rd_data <= 32'h0000_0000;
        end
        else
        begin
            rd_valid <= acc_valid && !acc_write;
            rd_hit <= acc_valid && next_rd_hit;
            if (acc_valid && !acc_write)
                rd_data <= next_rd_data;
        end
    end

    // Legacy combined view and datapath controls, from flops
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            legacy_rdata <= 32'h0000_0000;
            alt_half_format <= 1'b0;
            default_nan_enable <= 1'b0;
            flush_zero_enable <= 1'b0;
            rounding_select <= FPCS_RN;
            half_flush_zero_enable <= 1'b0;
        end
        else
        begin
            // Status unknown until written after reset; registered, so this word settles a cycle late
            legacy_rdata <= fp_control | fp_status;
            alt_half_format <= fp_control[FPCS_AHP_BIT];
            default_nan_enable <= fp_control[FPCS_DN_BIT];
            flush_zero_enable <= fp_control[FPCS_FZ_BIT];
            rounding_select <= fpcs_round_t'(
                fp_control[FPCS_RM_HI:FPCS_RM_LO]);
            half_flush_zero_enable <= fp_control[FPCS_HALF_FLUSH_ZERO_ENABLE_BIT];
        end
    end
endmodule
`default_nettype wire

// ==== fpcs_regs_asserts.sv ====
// Port checker for the floating-point register bank.
// Assumes one mclk domain and binding onto fpcs_regs.
`timescale 1ns/1ps
`default_nettype none
module fpcs_regs_asserts
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [1:0] acc_op0,
    input wire logic [2:0] acc_op1,
    input wire logic [3:0] acc_crn,
    input wire logic [3:0] acc_crm,
    input wire logic [2:0] acc_op2,
    input wire logic [31:0] acc_wdata,
    input wire logic cmp_valid,
    input wire logic cmp_legacy,
    input wire logic [3:0] cmp_nzcv,
    input wire logic rd_valid,
    input wire logic rd_hit,
    input wire logic [31:0] rd_data,
    input wire logic [3:0] state_nzcv,
    input wire logic state_nzcv_valid,
    input wire logic flush_zero_enable
);
    import fpcs_pkg::*;
    // Decode of the move under way
    wire [12:0] pre = {acc_op0, acc_op1, acc_crn, acc_crm};
    wire own = pre == {FPCS_OP0, FPCS_OP1, FPCS_CRN, FPCS_CRM};
    wire ft = pre == {FPCS_FEAT_OP0, FPCS_FEAT_OP1, FPCS_FEAT_CRN,
        FPCS_FEAT_CRM};
    wire rd = acc_valid && !acc_write;
    wire wr = acc_valid && acc_write;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_rd_answer; rd_valid == $past(rd); endproperty
    property p_hit; rd && own && acc_op2 < 3'h2 |=> rd_hit; endproperty
    property p_miss; rd && !own && !ft |=> !rd_hit && rd_data == 0; endproperty
    property p_f0; rd && ft && acc_op2 == 3'h0 |=> rd_data == 32'h1011_0222;
    endproperty
    property p_f2; rd && ft && acc_op2 == 3'h2 |=> rd_data == 32'h0000_0043;
    endproperty
    property p_ctl_rsv; rd && own && acc_op2 == 3'h0 |=>
        (rd_data & 32'hf830_0000) == 0 && rd_data[18:0] == 0; endproperty
    property p_st_rsv; rd && own && acc_op2 == 3'h1 |=>
        rd_data[26:8] == 0 && rd_data[6:5] == 0; endproperty
    property p_fz; wr && own && acc_op2 == 3'h0 |-> ##2
        flush_zero_enable == $past(acc_wdata[24], 2); endproperty
    property p_wide; cmp_valid && !cmp_legacy |=>
        state_nzcv_valid ##0 state_nzcv == $past(cmp_nzcv); endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("no read answer");
    a_hit: assert property (p_hit)
        else $error("mapped move missed");
    a_miss: assert property (p_miss)
        else $error("unmapped move hit");
    a_f0: assert property (p_f0)
        else $error("feature 0 wrong");
    a_f2: assert property (p_f2)
        else $error("feature 2 wrong");
    a_ctl_rsv: assert property (p_ctl_rsv)
        else $error("control rsv set");
    a_st_rsv: assert property (p_st_rsv)
        else $error("status rsv set");
    a_fz: assert property (p_fz)
        else $error("flush output late");
    a_wide: assert property (p_wide)
        else $error("wide flags lost");
    c_hit: cover property (rd_valid && rd_hit);
    c_wide: cover property (state_nzcv_valid);
    c_fz: cover property (flush_zero_enable);
endmodule
bind fpcs_regs fpcs_regs_asserts u_chk (.*);
`default_nettype wire

// ==== fpcs_pipe_model.sv ====
// Pipeline model issuing one decoded system-register move on request.
// Assumes the bench raises go for one cycle per move.
`timescale 1ns/1ps
`default_nettype none
module fpcs_pipe_model
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    input wire logic go_w,
    input wire logic [15:0] go_e,
    input wire logic [31:0] go_d,
    output logic acc_valid,
    output logic acc_write,
    output logic [1:0] acc_op0,
    output logic [2:0] acc_op1,
    output logic [3:0] acc_crn,
    output logic [3:0] acc_crm,
    output logic [2:0] acc_op2,
    output logic [31:0] acc_wdata
);
    // Idle fields toggle so a stale move never looks valid data
    always_ff @(posedge mclk)
    begin
        acc_valid <= go && !rst;
        acc_write <= go_w;
        // Encoding held with valid for the taking edge
        if (go)
            {acc_op0, acc_op1, acc_crn, acc_crm, acc_op2} <= go_e;
        else
            {acc_op0, acc_op1, acc_crn, acc_crm, acc_op2} <= ~go_e;
        acc_wdata <= go ? go_d : ~acc_wdata;
    end
endmodule
`default_nettype wire

// ==== tb_fp_control_status_regs.sv ====
// Bench for the register bank, driving moves through the pipeline model.
// Assumes 200 MHz mclk and synchronous high reset.
`timescale 1ns/1ps
`default_nettype none
module tb_fp_control_status_regs;
    import fpcs_pkg::*;
    // Packed as op0 op1 CRn CRm op2, most significant first
    localparam logic [15:0] CTL = 16'hda20;
    localparam logic [15:0] STA = 16'hda21;
    localparam logic [15:0] F0 = 16'hc018;
    localparam logic [31:0] FV [3] = '{32'h1011_0222, 32'h1321_1111,
        32'h0000_0043};
    logic mclk = 1'b0, rst = 1'b1, go = 1'b0, go_w = 1'b0;
    logic [15:0] go_e = 16'h0;
    logic [31:0] go_d = 32'h0, legacy_wdata = 32'h0, ex;
    logic legacy_valid = 1'b0, legacy_write = 1'b0, sat_event = 1'b0;
    logic cmp_valid = 1'b0, cmp_legacy = 1'b0;
    logic [3:0] cmp_nzcv = 4'h0;
    logic [5:0] exc_event = 6'h0;
    logic acc_valid, acc_write, rd_valid, rd_hit, state_nzcv_valid;
    logic [1:0] acc_op0;
    logic [2:0] acc_op1, acc_op2;
    logic [3:0] acc_crn, acc_crm, state_nzcv;
    logic [31:0] acc_wdata, rd_data, legacy_rdata;
    logic alt_half_format, default_nan_enable, flush_zero_enable;
    logic half_flush_zero_enable;
    fpcs_round_t rounding_select;
    int failures = 0, checked = 0, i;
    wire [5:0] outs = {alt_half_format, default_nan_enable, flush_zero_enable,
        rounding_select, half_flush_zero_enable};
    fpcs_pipe_model u_pipe (.*);
    fpcs_regs DUT (.*);
    // 5 ns clock
    always #2.5 mclk = ~mclk;
    task ck(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One move; read answer is sampled one edge after it is taken
    task mv(input logic w, input logic [15:0] e, input logic [31:0] d);
        @(posedge mclk);
        go <= 1'b1;
        go_w <= w;
        go_e <= e;
        go_d <= d;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        #1;
        ck({31'h0, rd_valid}, {31'h0, !w});
    endtask
    task rdk(input logic [15:0] e, input logic [31:0] x);
        mv(1'b0, e, 32'h0);
        ck(rd_data, x);
    endtask
    // Event and compare pulses last one cycle
    task pe(input logic s, input logic [5:0] x, input logic c, input logic l);
        @(posedge mclk);
        sat_event <= s;
        exc_event <= x;
        cmp_valid <= c;
        cmp_legacy <= l;
        @(posedge mclk);
        {sat_event, exc_event, cmp_valid} <= 8'h0;
        #1;
    endtask
    task test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rdk(CTL, 32'h0);
        ck({26'h0, outs}, 32'h0);
        for (i = 0; i < 3; i++)
        begin
            mv(1'b1, F0 + 16'(i), 32'hffff_ffff);
            rdk(F0 + 16'(i), FV[i]);
        end
        $display("features done");
        mv(1'b1, CTL, 32'hffff_ffff);
        rdk(CTL, 32'h07c8_0000);
        ck({26'h0, outs}, 32'h3f);
        for (i = 0; i < 4; i++)
        begin
            mv(1'b1, CTL, 32'(i) << 22);
            repeat (2) @(posedge mclk);
            #1;
            ck({26'h0, outs}, 32'(i) << 1);
        end
        $display("control done");
        mv(1'b1, STA, 32'hffff_ffff);
        rdk(STA, 32'hf800_009f);
        mv(1'b1, STA, 32'h0);
        ex = 32'h0;
        for (i = 0; i < 6; i++)
        begin
            pe(1'b0, 6'(1 << i), 1'b0, 1'b0);
            ex |= (i == 5) ? 32'h80 : 32'(1 << i);
            rdk(STA, ex);
        end
        pe(1'b1, 6'h0, 1'b0, 1'b0);
        rdk(STA, ex | 32'h0800_0000);
        mv(1'b1, STA, 32'h0800_0000);
        rdk(STA, 32'h0800_0000);
        cmp_nzcv <= 4'ha;
        pe(1'b0, 6'h0, 1'b1, 1'b1);
        ck({31'h0, state_nzcv_valid}, 32'h0);
        rdk(STA, 32'ha800_0000);
        cmp_nzcv <= 4'h5;
        pe(1'b0, 6'h0, 1'b1, 1'b0);
        ck({27'h0, state_nzcv_valid, state_nzcv}, 32'h15);
        rdk(STA, 32'ha800_0000);
        $display("status done");
        @(posedge mclk);
        {legacy_valid, legacy_write} <= 2'b11;
        legacy_wdata <= 32'h0100_0000;
        @(posedge mclk);
        {legacy_valid, legacy_write} <= 2'b00;
        rdk(CTL, 32'h0100_0000);
        rdk(STA, 32'h0);
        ck(legacy_rdata, 32'h0100_0000);
        rdk(CTL + 16'h7, 32'h0);
        ck({31'h0, rd_hit}, 32'h0);
        $display("legacy and unmapped done");
        test_done;
    end
endmodule
`default_nettype wire
